// >>> core/mcf_codec.sv
`timescale 1ns/1ps
module mcf_codec (
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic START_IN,
  input wire logic RX_VALID_IN,
  input wire logic [7:0] RX_DATA_IN,
  output logic RX_READY_OUT,
  input wire logic SCAN_END_IN,
  input wire logic SEQ_STEP_HIT_IN,
  output logic READ_TRIGGER_OUT,
  output logic FORMAT_ERROR_OUT,
  output mcf_pkg::mcf_fields_s FIELDS_OUT,
  input wire logic [4:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT
);
  mcf_pkg::mcf_state_e state_reg, state_next;
  mcf_pkg::mcf_fields_s fields_reg;
  logic [1:0] ctrl_reg;
  logic ascii_reg, mon_reg, err_reg, hit_reg, nofile_reg;
  logic trig_reg, ferr_reg, ack_reg;
  logic [3:0] err_field_reg, cnt_reg, len;
  logic [1:0] scan_cnt_reg;
  logic [31:0] acc_reg, acc_next, rd_reg;
  logic [3:0] nib;
  logic nib_ok, rx_fire, fld_last, numeric, viol;
  logic [15:0] w;

  mcf_hex_digit u_hex (
    .char_in(RX_DATA_IN),
    .nibble_out(nib),
    .valid_out(nib_ok)
  );

  assign RX_READY_OUT = state_reg != mcf_pkg::S_IDLE &&
    state_reg != mcf_pkg::S_DECIDE && state_reg != mcf_pkg::S_WSCAN &&
    state_reg != mcf_pkg::S_WHIT && state_reg != mcf_pkg::S_FIRE;
  assign rx_fire = RX_VALID_IN && RX_READY_OUT;
  assign numeric = state_reg != mcf_pkg::S_NAME;
  assign fld_last = rx_fire && cnt_reg == len - 4'h1;
  assign w = acc_next[15:0];

  // Field length depends on the field and on the framing.
  always_comb begin
    case (state_reg)
      mcf_pkg::S_COND, mcf_pkg::S_FIXED: begin
        len = ascii_reg ? mcf_pkg::LEN_COND_A : mcf_pkg::LEN_COND_B;
      end
      mcf_pkg::S_NAME: begin
        len = mcf_pkg::LEN_NAME;
      end
      mcf_pkg::S_SEQ: begin
        len = ascii_reg ? mcf_pkg::LEN_SEQ_A : mcf_pkg::LEN_SEQ_B;
      end
      default: begin
        len = ascii_reg ? mcf_pkg::LEN_WORD_A : mcf_pkg::LEN_WORD_B;
      end
    endcase
  end

  // ASCII digits arrive most significant first, binary bytes low first.
  always_comb begin
    if (ascii_reg) begin
      acc_next = {acc_reg[27:0], nib};
    end else begin
      acc_next = acc_reg |
        ({24'h000000, RX_DATA_IN} << {cnt_reg[1:0], 3'b000});
    end
  end

  // Checks on ASCII digits, name characters and completed fields; a bad field only flags, the frame runs on.
  always_comb begin
    viol = 1'b0;
    if (rx_fire && numeric && ascii_reg && !nib_ok) begin
      viol = 1'b1;
    end
    if (rx_fire && state_reg == mcf_pkg::S_NAME) begin
      if ((nofile_reg || cnt_reg == mcf_pkg::NAME_ATTR_IDX) &&
          RX_DATA_IN != mcf_pkg::SPACE_CODE) begin
        viol = 1'b1;
      end
    end
    if (fld_last) begin
      case (state_reg)
        mcf_pkg::S_COND: begin
          if (acc_next[7:0] < mcf_pkg::COND_MIN ||
              acc_next[7:0] > mcf_pkg::COND_MAX) begin
            viol = 1'b1;
          end
        end
        mcf_pkg::S_FIXED: begin
          if (acc_next[7:0] != mcf_pkg::FIXED_VAL) begin
            viol = 1'b1;
          end
        end
        mcf_pkg::S_FILE: begin
          if (nofile_reg && w != mcf_pkg::FILE_NONE) begin
            viol = 1'b1;
          end else if (w > mcf_pkg::FILE_MAX && w != mcf_pkg::FILE_UNKNOWN) begin
            viol = 1'b1;
          end
        end
        mcf_pkg::S_PAT: begin
          if (w != mcf_pkg::PAT_NONE && w != mcf_pkg::PAT_CHART) begin
            viol = 1'b1;
          end else if (nofile_reg && w != mcf_pkg::PAT_NONE) begin
            viol = 1'b1;
          end
        end
        mcf_pkg::S_BLOCK, mcf_pkg::S_STEP: begin
          if ((nofile_reg || fields_reg.pattern == mcf_pkg::PAT_NONE) &&
              w != 16'h0000) begin
            viol = 1'b1;
          end else if (w > (state_reg == mcf_pkg::S_BLOCK ?
                       mcf_pkg::BLOCK_MAX : mcf_pkg::STEP_MAX)) begin
            viol = 1'b1;
          end
        end
        mcf_pkg::S_SEQ: begin
          if (nofile_reg && acc_next != 32'h00000000) begin
            viol = 1'b1;
          end
        end
        default: begin
          viol = viol;
        end
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mcf_pkg::S_IDLE: begin
        if (START_IN) begin
          state_next = ctrl_reg[mcf_pkg::CTRL_MON_BIT] ?
            mcf_pkg::S_COND : mcf_pkg::S_FIRE;
        end
      end
      mcf_pkg::S_COND: if (fld_last) state_next = mcf_pkg::S_FIXED;
      mcf_pkg::S_FIXED: if (fld_last) state_next = mcf_pkg::S_FILE;
      mcf_pkg::S_FILE: if (fld_last) state_next = mcf_pkg::S_NAME;
      mcf_pkg::S_NAME: if (fld_last) state_next = mcf_pkg::S_PAT;
      mcf_pkg::S_PAT: if (fld_last) state_next = mcf_pkg::S_BLOCK;
      mcf_pkg::S_BLOCK: if (fld_last) state_next = mcf_pkg::S_STEP;
      mcf_pkg::S_STEP: if (fld_last) state_next = mcf_pkg::S_SEQ;
      mcf_pkg::S_SEQ: if (fld_last) state_next = mcf_pkg::S_DECIDE;
      mcf_pkg::S_DECIDE: begin
        if (err_reg) begin
          state_next = mcf_pkg::S_IDLE;
        end else if (fields_reg.file == mcf_pkg::FILE_UNKNOWN) begin
          state_next = mcf_pkg::S_WSCAN;
        end else if (fields_reg.pattern == mcf_pkg::PAT_CHART) begin
          state_next = mcf_pkg::S_WHIT;
        end else begin
          state_next = mcf_pkg::S_FIRE;
        end
      end
      mcf_pkg::S_WSCAN: begin
        if (SCAN_END_IN && scan_cnt_reg == mcf_pkg::SCANS_FOR_LOOKUP - 2'h1) begin
          state_next = fields_reg.pattern == mcf_pkg::PAT_CHART ?
            mcf_pkg::S_WHIT : mcf_pkg::S_FIRE;
        end
      end
      mcf_pkg::S_WHIT: begin
        if (SCAN_END_IN && (hit_reg || SEQ_STEP_HIT_IN)) begin
          state_next = mcf_pkg::S_FIRE;
        end
      end
      default: begin
        state_next = mcf_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_reg <= mcf_pkg::S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Framing and read kind are frozen at the start of a request.
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ascii_reg <= 1'b0;
      mon_reg <= 1'b0;
    end else if (state_reg == mcf_pkg::S_IDLE && START_IN) begin
      ascii_reg <= ctrl_reg[mcf_pkg::CTRL_ASCII_BIT];
      mon_reg <= ctrl_reg[mcf_pkg::CTRL_MON_BIT];
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cnt_reg <= 4'h0;
      acc_reg <= 32'h00000000;
    end else if (state_reg == mcf_pkg::S_IDLE || fld_last) begin
      cnt_reg <= 4'h0;
      acc_reg <= 32'h00000000;
    end else if (rx_fire) begin
      cnt_reg <= cnt_reg + 4'h1;
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fields_reg <= '0;
      nofile_reg <= 1'b0;
    end else if (fld_last) begin
      case (state_reg)
        mcf_pkg::S_COND: begin
          fields_reg.cond <= acc_next[7:0];
          nofile_reg <= acc_next[7:0] == mcf_pkg::COND_NOFILE_A ||
            acc_next[7:0] == mcf_pkg::COND_NOFILE_B;
        end
        mcf_pkg::S_FILE: fields_reg.file <= w;
        mcf_pkg::S_PAT: fields_reg.pattern <= w;
        mcf_pkg::S_BLOCK: fields_reg.block <= w;
        mcf_pkg::S_STEP: fields_reg.step <= w;
        mcf_pkg::S_SEQ: fields_reg.seq <= acc_next;
        default: fields_reg <= fields_reg;
      endcase
    end
  end

  // The first failing field is kept so software can see what went wrong.
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      err_reg <= 1'b0;
      err_field_reg <= 4'h0;
    end else if (state_reg == mcf_pkg::S_IDLE && START_IN) begin
      err_reg <= 1'b0;
      err_field_reg <= 4'h0;
    end else if (viol && !err_reg) begin
      err_reg <= 1'b1;
      err_field_reg <= state_reg;
    end
  end

  // A step hit is remembered until the end of the scan it belongs to.
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hit_reg <= 1'b0;
      scan_cnt_reg <= 2'h0;
    end else begin
      hit_reg <= !SCAN_END_IN && (hit_reg || SEQ_STEP_HIT_IN);
      if (state_reg != mcf_pkg::S_WSCAN) begin
        scan_cnt_reg <= 2'h0;
      end else if (SCAN_END_IN) begin
        scan_cnt_reg <= scan_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      trig_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      trig_reg <= state_reg == mcf_pkg::S_FIRE;
      ferr_reg <= state_reg == mcf_pkg::S_DECIDE && err_reg;
    end
  end

  assign READ_TRIGGER_OUT = trig_reg;
  assign FORMAT_ERROR_OUT = ferr_reg;
  assign FIELDS_OUT = fields_reg;

  // Each access is answered on the second cycle; the stall costs one cycle.
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_reg;

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ack_reg <= 1'b0;
      ctrl_reg <= mcf_pkg::CTRL_RESET;
      rd_reg <= 32'h00000000;
    end else begin
      ack_reg <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_reg;
      // A write lands only on the edge that completes the access, one edge after the stall ends.
      if (AVS_WRITE_IN && ack_reg && AVS_ADDRESS_IN == mcf_pkg::REG_CTRL) begin
        ctrl_reg <= AVS_WRITEDATA_IN[1:0];
      end
      if (AVS_READ_IN && !ack_reg) begin
        if (AVS_ADDRESS_IN == mcf_pkg::REG_CTRL) begin
          rd_reg <= {30'h00000000, ctrl_reg};
        end else if (AVS_ADDRESS_IN == mcf_pkg::REG_STATUS) begin
          rd_reg <= {22'h000000, err_field_reg, state_reg, nofile_reg, err_reg};
        end else if (AVS_ADDRESS_IN == mcf_pkg::REG_FILE) begin
          rd_reg <= {8'h00, fields_reg.cond, fields_reg.file};
        end else if (AVS_ADDRESS_IN == mcf_pkg::REG_CHART) begin
          rd_reg <= {fields_reg.block, fields_reg.step};
        end else if (AVS_ADDRESS_IN == mcf_pkg::REG_SEQ) begin
          rd_reg <= fields_reg.seq;
        end else begin
          rd_reg <= 32'h00000000;
        end
      end
    end
  end

  assign AVS_READDATA_OUT = rd_reg;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence unmon_start;
    state_reg == mcf_pkg::S_IDLE && START_IN &&
      !ctrl_reg[mcf_pkg::CTRL_MON_BIT];
  endsequence

  // The pulse shows two edges after start: one for FIRE, one for the flop.
  sequence fire_pulse;
    !READ_TRIGGER_OUT ##1 !READ_TRIGGER_OUT ##1 READ_TRIGGER_OUT ##1
      !READ_TRIGGER_OUT;
  endsequence

  a_cond_range: assert property (READ_TRIGGER_OUT && mon_reg |->
    fields_reg.cond >= mcf_pkg::COND_MIN &&
    fields_reg.cond <= mcf_pkg::COND_MAX)
    else $error("Read started with bad condition code.");
  a_unmon_fire: assert property (unmon_start |-> fire_pulse)
    else $error("Unmonitored read did not fire at once.");
  a_fixed_check: assert property (state_reg == mcf_pkg::S_FIXED && fld_last &&
    acc_next[7:0] != mcf_pkg::FIXED_VAL |=> err_reg)
    else $error("Bad fixed value not flagged.");
  a_lookup_wait: assert property (state_reg == mcf_pkg::S_WSCAN &&
    state_next != mcf_pkg::S_WSCAN |-> SCAN_END_IN && scan_cnt_reg == 2'h1)
    else $error("Unknown file left wait too early.");
  a_chart_scan: assert property (state_reg == mcf_pkg::S_WHIT &&
    state_next == mcf_pkg::S_FIRE |-> SCAN_END_IN ##2 READ_TRIGGER_OUT)
    else $error("Chart read not at scan end.");
  a_nofile_zero: assert property (READ_TRIGGER_OUT && mon_reg && nofile_reg |->
    fields_reg.file == mcf_pkg::FILE_NONE && fields_reg.seq == 32'h00000000 &&
    fields_reg.pattern == mcf_pkg::PAT_NONE && fields_reg.block == 16'h0000)
    else $error("No-file read carried nonzero fields.");
  a_chart_limits: assert property (READ_TRIGGER_OUT && mon_reg |->
    fields_reg.block <= mcf_pkg::BLOCK_MAX &&
    fields_reg.step <= mcf_pkg::STEP_MAX &&
    (fields_reg.pattern == mcf_pkg::PAT_NONE ||
     fields_reg.pattern == mcf_pkg::PAT_CHART))
    else $error("Chart fields out of range at read.");
  a_err_report: assert property (state_reg == mcf_pkg::S_DECIDE && err_reg |=>
    FORMAT_ERROR_OUT ##1 (state_reg == mcf_pkg::S_IDLE && !READ_TRIGGER_OUT))
    else $error("Format error not reported cleanly.");
  a_bus_answer: assert property ((AVS_READ_IN || AVS_WRITE_IN) &&
    AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("Bus access not answered next cycle.");
endmodule // mcf_codec

// >>> core/mcf_pkg.sv
package mcf_pkg;

  localparam logic [7:0] COND_MIN = 8'h01;
  localparam logic [7:0] COND_MAX = 8'h05;
  localparam logic [7:0] COND_NOFILE_A = 8'h02;
  localparam logic [7:0] COND_NOFILE_B = 8'h04;
  localparam logic [7:0] FIXED_VAL = 8'h0f;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [15:0] FILE_NONE = 16'h0000;
  localparam logic [15:0] FILE_MAX = 16'h0100;
  localparam logic [15:0] FILE_UNKNOWN = 16'hffff;
  localparam logic [15:0] PAT_NONE = 16'h0000;
  localparam logic [15:0] PAT_CHART = 16'h0003;
  localparam logic [15:0] BLOCK_MAX = 16'h013f;
  localparam logic [15:0] STEP_MAX = 16'h01ff;

  // Field lengths in received characters, ASCII then binary framing.
  localparam logic [3:0] LEN_COND_A = 4'h2;
  localparam logic [3:0] LEN_COND_B = 4'h1;
  localparam logic [3:0] LEN_WORD_A = 4'h4;
  localparam logic [3:0] LEN_WORD_B = 4'h2;
  localparam logic [3:0] LEN_SEQ_A = 4'h8;
  localparam logic [3:0] LEN_SEQ_B = 4'h4;
  localparam logic [3:0] LEN_NAME = 4'hc;
  localparam logic [3:0] NAME_ATTR_IDX = 4'hb;

  // Scan ends to wait so that one whole scan lies inside the delay.
  localparam logic [1:0] SCANS_FOR_LOOKUP = 2'h2;

  // ASCII hexadecimal digit codes.
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UF = 8'h46;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LF = 8'h66;
  localparam logic [7:0] HEX_TEN = 8'h0a;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_FILE = 5'h08;
  localparam logic [4:0] REG_CHART = 5'h0c;
  localparam logic [4:0] REG_SEQ = 5'h10;
  localparam int CTRL_ASCII_BIT = 0;
  localparam int CTRL_MON_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_COND = 4'h1,
    S_FIXED = 4'h3,
    S_FILE = 4'h2,
    S_NAME = 4'h6,
    S_PAT = 4'h7,
    S_BLOCK = 4'h5,
    S_STEP = 4'h4,
    S_SEQ = 4'hc,
    S_DECIDE = 4'hd,
    S_WSCAN = 4'hf,
    S_WHIT = 4'he,
    S_FIRE = 4'ha
  } mcf_state_e;

  typedef struct packed {
    logic [7:0] cond;
    logic [15:0] file;
    logic [15:0] pattern;
    logic [15:0] block;
    logic [15:0] step;
    logic [31:0] seq;
  } mcf_fields_s;

endpackage

// >>> core/mcf_hex_digit.sv
`timescale 1ns/1ps
module mcf_hex_digit (
  input wire logic [7:0] char_in,
  output logic [3:0] nibble_out,
  output logic valid_out
);
  logic [7:0] diff;

  always_comb begin
    diff = 8'h00;
    valid_out = 1'b1;
    if (char_in >= mcf_pkg::CH_0 && char_in <= mcf_pkg::CH_9) begin
      diff = char_in - mcf_pkg::CH_0;
    end else if (char_in >= mcf_pkg::CH_UA && char_in <= mcf_pkg::CH_UF) begin
      diff = char_in - mcf_pkg::CH_UA + mcf_pkg::HEX_TEN;
    end else if (char_in >= mcf_pkg::CH_LA && char_in <= mcf_pkg::CH_LF) begin
      diff = char_in - mcf_pkg::CH_LA + mcf_pkg::HEX_TEN;
    end else begin
      valid_out = 1'b0;
    end
    nibble_out = diff[3:0];
  end
endmodule // mcf_hex_digit

// >>> tb/mcf_host_model.sv
`timescale 1ns/1ps
module mcf_host_model (
  input wire logic clock_in,
  input wire logic rx_ready_in,
  output logic start_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic stall_out
);
  // Stall is sticky, so a byte that was never taken cannot go unnoticed.
  initial begin
    start_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    stall_out = 1'b0;
  end

  task automatic put_byte(input logic [7:0] b);
    int n;
    n = 0;
    rx_valid_out <= 1'b1;
    rx_data_out <= b;
    do begin
      @(posedge clock_in);
      n++;
    end while (rx_ready_in !== 1'b1 && n < 50);
    if (n >= 50) stall_out <= 1'b1;
  endtask

  task automatic put_num(input logic ascii, input logic [31:0] v,
                         input int nb);
    logic [3:0] nib;
    if (ascii) begin
      for (int i = 2 * nb - 1; i >= 0; i--) begin
        nib = v[4*i+:4];
        put_byte(nib < 4'ha ? {4'h3, nib} : 8'h37 + {4'h0, nib});
      end
    end else begin
      for (int i = 0; i < nb; i++) put_byte(v[8*i+:8]);
    end
  endtask

  task automatic send(input logic ascii, input logic mon,
    input logic [7:0] cond, input logic [7:0] fx, input logic [15:0] file,
    input logic [15:0] pat, input logic [15:0] blk, input logic [15:0] stp,
    input logic [31:0] seq);
    @(posedge clock_in);
    start_out <= 1'b1;
    @(posedge clock_in);
    start_out <= 1'b0;
    if (mon) begin
      put_num(ascii, {24'h0, cond}, 1);
      put_num(ascii, {24'h0, fx}, 1);
      put_num(ascii, {16'h0, file}, 2);
      for (int i = 0; i < 11; i++)
        put_byte(cond[0] && i < 6 ? 8'h41 + i[7:0] : 8'h20);
      put_byte(8'h20);
      put_num(ascii, {16'h0, pat}, 2);
      put_num(ascii, {16'h0, blk}, 2);
      put_num(ascii, {16'h0, stp}, 2);
      put_num(ascii, seq, 4);
    end
    rx_valid_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
  endtask
endmodule // mcf_host_model

// >>> tb/monitor_condition_field_codec_test.sv
`timescale 1ns/1ps
module monitor_condition_field_codec_test;
  logic clock, nrst, start, rx_valid, rx_ready, scan_end, hit, trig, ferr;
  logic stall, av_rd, av_wr, av_wait;
  logic [7:0] rx_data;
  logic [4:0] av_addr;
  logic [31:0] av_wdata, av_rdata, rd;
  mcf_pkg::mcf_fields_s fields;
  int num_errors;
  int check_count;

  mcf_codec uut (.CLOCK_IN(clock), .NRST_IN(nrst), .START_IN(start),
    .RX_VALID_IN(rx_valid), .RX_DATA_IN(rx_data), .RX_READY_OUT(rx_ready),
    .SCAN_END_IN(scan_end), .SEQ_STEP_HIT_IN(hit),
    .READ_TRIGGER_OUT(trig), .FORMAT_ERROR_OUT(ferr), .FIELDS_OUT(fields),
    .AVS_ADDRESS_IN(av_addr), .AVS_READ_IN(av_rd), .AVS_WRITE_IN(av_wr),
    .AVS_WRITEDATA_IN(av_wdata), .AVS_READDATA_OUT(av_rdata),
    .AVS_WAITREQUEST_OUT(av_wait));

  mcf_host_model host (.clock_in(clock), .rx_ready_in(rx_ready),
    .start_out(start), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .stall_out(stall));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic final_report();
    $display("checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [103:0] exp,
                     input logic [103:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic av(input logic wr, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (av_wait !== 1'b0 && n < 20);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic outcome(input logic exp_trig);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (trig !== 1'b1 && ferr !== 1'b1 && n < 100);
    if (n >= 100) begin
      num_errors++;
      final_report();
    end else begin
      chk("read trigger", {103'h0, exp_trig}, {103'h0, trig});
      chk("format error", {103'h0, !exp_trig}, {103'h0, ferr});
    end
  endtask

  task automatic quiet(input int cycles);
    repeat (cycles) begin
      @(posedge clock);
      chk("no pulse", 104'h0, {102'h0, trig, ferr});
    end
  endtask

  task automatic scan(input logic h);
    @(posedge clock);
    scan_end <= 1'b1;
    hit <= h;
    @(posedge clock);
    scan_end <= 1'b0;
    hit <= 1'b0;
  endtask

  task automatic frame(input logic ascii, input logic mon,
    input logic [7:0] cond, input logic [7:0] fx, input logic [15:0] file,
    input logic [15:0] pat, input logic [15:0] blk, input logic [15:0] stp,
    input logic [31:0] seq);
    av(1'b1, mcf_pkg::REG_CTRL, {30'h0, mon, ascii}, rd);
    host.send(ascii, mon, cond, fx, file, pat, blk, stp, seq);
    chk("host stall", 104'h0, {103'h0, stall});
  endtask

  task automatic t_regs();
    av(1'b0, mcf_pkg::REG_CTRL, 32'h0, rd);
    chk("ctrl reset", 104'h2, {72'h0, rd});
    av(1'b0, 5'h14, 32'h0, rd);
    chk("unmapped read", 104'h0, {72'h0, rd});
  endtask

  task automatic t_direct();
    frame(1'b0, 1'b1, 8'h01, 8'h0f, 16'h0100, 16'h0, 16'h0, 16'h0,
          32'h12345678);
    outcome(1'b1);
    chk("fields", {8'h01, 16'h0100, 48'h0, 32'h12345678}, fields);
    av(1'b0, mcf_pkg::REG_FILE, 32'h0, rd);
    chk("file reg", {72'h0, 16'h0001, 16'h0100}, {72'h0, rd});
    frame(1'b1, 1'b1, 8'h05, 8'h0f, 16'h001f, 16'h0, 16'h0, 16'h0,
          32'h0000abcd);
    outcome(1'b1);
    chk("fields", {8'h05, 16'h001f, 48'h0, 32'h0000abcd}, fields);
  endtask

  task automatic t_nofile();
    frame(1'b0, 1'b1, 8'h02, 8'h0f, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    outcome(1'b1);
    frame(1'b1, 1'b1, 8'h04, 8'h0f, 16'h0001, 16'h0, 16'h0, 16'h0, 32'h0);
    outcome(1'b0);
    frame(1'b0, 1'b1, 8'h04, 8'h0f, 16'h0, 16'h3, 16'h0, 16'h0, 32'h0);
    outcome(1'b0);
    frame(1'b0, 1'b1, 8'h02, 8'h0f, 16'h0, 16'h0, 16'h0, 16'h0, 32'h1);
    outcome(1'b0);
  endtask

  task automatic t_errors();
    frame(1'b0, 1'b1, 8'h00, 8'h0f, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    outcome(1'b0);
    av(1'b0, mcf_pkg::REG_STATUS, 32'h0, rd);
    chk("status", {94'h0, 4'(mcf_pkg::S_COND), 4'(mcf_pkg::S_IDLE), 2'b01},
        {72'h0, rd});
    frame(1'b1, 1'b1, 8'h06, 8'h0f, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    outcome(1'b0);
    frame(1'b0, 1'b1, 8'h01, 8'h0e, 16'h1, 16'h0, 16'h0, 16'h0, 32'h0);
    outcome(1'b0);
    frame(1'b0, 1'b1, 8'h01, 8'h0f, 16'h0101, 16'h0, 16'h0, 16'h0, 32'h0);
    outcome(1'b0);
    frame(1'b1, 1'b1, 8'h01, 8'h0f, 16'h1, 16'h1, 16'h0, 16'h0, 32'h0);
    outcome(1'b0);
    frame(1'b0, 1'b1, 8'h01, 8'h0f, 16'h1, 16'h3, 16'h140, 16'h0, 32'h0);
    outcome(1'b0);
    frame(1'b0, 1'b1, 8'h03, 8'h0f, 16'h1, 16'h3, 16'h0, 16'h200, 32'h0);
    outcome(1'b0);
    frame(1'b0, 1'b1, 8'h01, 8'h0f, 16'h1, 16'h0, 16'h1, 16'h0, 32'h0);
    outcome(1'b0);
  endtask

  // Waits stay short so a design stuck in a wait state fails fast.
  task automatic t_waits();
    frame(1'b0, 1'b1, 8'h01, 8'h0f, 16'hffff, 16'h0, 16'h0, 16'h0, 32'h9);
    quiet(6);
    scan(1'b0);
    quiet(6);
    scan(1'b0);
    outcome(1'b1);
    frame(1'b1, 1'b1, 8'h03, 8'h0f, 16'h1, 16'h3, 16'h13f, 16'h1ff, 32'h5);
    quiet(6);
    scan(1'b0);
    quiet(6);
    scan(1'b1);
    outcome(1'b1);
    chk("fields", {8'h03, 16'h1, 16'h3, 16'h13f, 16'h1ff, 32'h5}, fields);
    av(1'b0, mcf_pkg::REG_CHART, 32'h0, rd);
    chk("chart reg", {72'h0, 16'h013f, 16'h01ff}, {72'h0, rd});
    av(1'b0, mcf_pkg::REG_SEQ, 32'h0, rd);
    chk("seq reg", {72'h0, 32'h5}, {72'h0, rd});
  endtask

  initial begin
    nrst = 1'b0;
    scan_end = 1'b0;
    hit = 1'b0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_addr = 5'h00;
    av_wdata = 32'h0;
    num_errors = 0;
    check_count = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_direct();
    t_nofile();
    t_errors();
    t_waits();
    frame(1'b0, 1'b0, 8'h0, 8'h0, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    outcome(1'b1);
    chk("ready after unmonitored", 104'h0, {103'h0, rx_ready});
    final_report();
  end
endmodule // monitor_condition_field_codec_test
